/* src/csm_regs.vh */
// constants for the idle-state request mapper
`ifndef CSM_REGS_VH
`define CSM_REGS_VH
// requested idle-state types (2 bits)
`define CSM_REQ_C0 2'h0
`define CSM_REQ_C1 2'h1
`define CSM_REQ_C2 2'h2
`define CSM_REQ_C3 2'h3
// internal sleep-state codes (3 bits)
`define CSM_IN_C0 3'h0
`define CSM_IN_C1 3'h1
`define CSM_IN_C3 3'h3
`define CSM_IN_C6 3'h6
`define CSM_IN_C7 3'h7
// idle history
`define CSM_HIST_W 4
`define CSM_HIST_RST 4'h0
`define CSM_SHORT_RES 16'h0100
`define CSM_LONG_RES 16'h4000
`define CSM_RES_W 16
// frequency ratio width and core count
`define CSM_RATIO_W 8
`define CSM_NCORE 4
`define CSM_CORE_W 2
`endif

/* src/csm_mapper.v */
// idle-state request mapping, demotion and boost frequency selection
`timescale 1ns/10ps
`default_nettype none
`include "csm_regs.vh"

// Notes on behaviour
// - first-generation mobile: C0->C0, C1->C1, C2->C3, C3->C7.
// - second generation: C0->C0, C1->C1, C2->C3, C3->C6 or C7.
// - mobile parts flush last-level cache once cores reach C7.
// - deep request may demote C6/C7 to C3, or C3 to C1.
// - demote when history shows deeper state less energy efficient.
// - demote when history shows deeper state would hurt performance.
// - after long demoted residency, wake core; repeated request goes deep.
// - on P0 request, core frequency lies between P1 and P0.
// - top boost only with at most one busy core; lower limits for two to four.
// - core frequency never below P1 normally, even all cores busy.
// - second generation splits spare budget between cores and graphics.
// - internal C3 stops clocks and snoops, allows memory self-refresh.
module csm_mapper (
  // clock and reset
  input wire clk_i,
  input wire reset_i,
  // configuration
  input wire gen2_i,
  input wire mobile_i,
  input wire c7_sel_i,
  input wire [`CSM_HIST_W-1:0] hist_thresh_i,
  input wire [`CSM_HIST_W-1:0] perf_thresh_i,
  // idle request per core
  input wire [`CSM_NCORE-1:0] req_valid_i,
  input wire [2*`CSM_NCORE-1:0] req_type_i,
  input wire [`CSM_NCORE-1:0] wake_i,
  // performance request and limits
  input wire p0_req_i,
  input wire [`CSM_RATIO_W-1:0] p1_ratio_i,
  input wire [`CSM_RATIO_W-1:0] p0_ratio_i,
  input wire [`CSM_RATIO_W-1:0] lim2_ratio_i,
  input wire [`CSM_RATIO_W-1:0] lim4_ratio_i,
  input wire gfx_demand_i,
  // state outputs
  output reg [3*`CSM_NCORE-1:0] cstate_o,
  output reg [`CSM_NCORE-1:0] demoted_o,
  output reg [`CSM_NCORE-1:0] wake_req_o,
  output reg llc_flush_o,
  output reg clk_stop_o,
  output reg snoop_stop_o,
  output reg self_refresh_o,
  output reg [`CSM_RATIO_W-1:0] core_ratio_o,
  output reg gfx_boost_o
);

  ////////////////////////////////////////////////////////////////////////
  // mapping of a requested type onto internal states

  function [2:0] map_req;
    input [1:0] t;
    input g2;
    input deep7;
    begin
      case (t)
        `CSM_REQ_C0: map_req = `CSM_IN_C0;
        `CSM_REQ_C1: map_req = `CSM_IN_C1;
        `CSM_REQ_C2: map_req = `CSM_IN_C3;
        `CSM_REQ_C3: map_req = (g2 && !deep7) ? `CSM_IN_C6 : `CSM_IN_C7;
        default: map_req = `CSM_IN_C0;
      endcase
    end
  endfunction

  // c0 and c1 pass through unchanged
  // demotion target
  function [2:0] demote_of;
    input [2:0] s;
    begin
      if (s == `CSM_IN_C6 || s == `CSM_IN_C7)
        demote_of = `CSM_IN_C3;
      else if (s == `CSM_IN_C3)
        demote_of = `CSM_IN_C1;
      else
        demote_of = s;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // per-core idle history and state

  wire [`CSM_NCORE-1:0] in_c7;
  wire [`CSM_NCORE-1:0] in_c3up;
  wire [`CSM_NCORE-1:0] busy;

  // one history slice per core; cores never share a counter or a timer
  genvar g;
  generate
    for (g = 0; g < `CSM_NCORE; g = g + 1) begin : core
      reg [`CSM_HIST_W-1:0] short_cnt_r;
      reg [`CSM_RES_W-1:0] res_r;
      reg undemote_r;
      wire [2:0] want = map_req(req_type_i[2*g+1:2*g], gen2_i, c7_sel_i);
      wire deep_req = (want != `CSM_IN_C0) && (want != `CSM_IN_C1);
      wire ineff = short_cnt_r >= hist_thresh_i;
      // performance: short stays past a tighter mark
      wire perf_hit = short_cnt_r >= perf_thresh_i;
      wire [2:0] cur = cstate_o[3*g+2:3*g];
      wire deep_now = (cur != `CSM_IN_C0) && (cur != `CSM_IN_C1);

      always @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          short_cnt_r <= `CSM_HIST_RST;
          res_r <= {`CSM_RES_W{1'b0}};
          undemote_r <= 1'b0;
          cstate_o[3*g+2:3*g] <= `CSM_IN_C0;
          demoted_o[g] <= 1'b0;
          wake_req_o[g] <= 1'b0;
        end else begin
          wake_req_o[g] <= 1'b0;
          if (cur != `CSM_IN_C0 && res_r != {`CSM_RES_W{1'b1}})
            res_r <= res_r + 1'b1;
          if (req_valid_i[g] && cur == `CSM_IN_C0) begin
            res_r <= {`CSM_RES_W{1'b0}};
            if (deep_req && (ineff || perf_hit) && !undemote_r) begin
              cstate_o[3*g+2:3*g] <= demote_of(want);
              demoted_o[g] <= 1'b1;
            end else begin
              cstate_o[3*g+2:3*g] <= want;
              demoted_o[g] <= 1'b0;
            end
            undemote_r <= 1'b0;
          end else if (wake_i[g] && cur != `CSM_IN_C0) begin
            if (deep_now && res_r < `CSM_SHORT_RES) begin
              if (short_cnt_r != {`CSM_HIST_W{1'b1}})
                short_cnt_r <= short_cnt_r + 1'b1;
            end else if (deep_now && short_cnt_r != `CSM_HIST_RST) begin
              // a long stay pays one back, so old bursts stop forcing demotion
              short_cnt_r <= short_cnt_r - 1'b1;
            end
            cstate_o[3*g+2:3*g] <= `CSM_IN_C0;
            demoted_o[g] <= 1'b0;
          end else if (demoted_o[g] && res_r >= `CSM_LONG_RES) begin
            // hand control back
            // history cleared and undemote_r set, so the reissued deep request skips demotion and goes through
            cstate_o[3*g+2:3*g] <= `CSM_IN_C0;
            demoted_o[g] <= 1'b0;
            wake_req_o[g] <= 1'b1;
            undemote_r <= 1'b1;
            short_cnt_r <= `CSM_HIST_RST;
          end
        end
      end

      assign in_c7[g] = (cur == `CSM_IN_C7);
      assign in_c3up[g] = deep_now;
      assign busy[g] = (cur == `CSM_IN_C0);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // package-level sleep controls

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      llc_flush_o <= 1'b0;
      clk_stop_o <= 1'b0;
      snoop_stop_o <= 1'b0;
      self_refresh_o <= 1'b0;
    end else begin
      // all package controls lag the core states by one cycle
      // flush when mobile and all cores in C7
      llc_flush_o <= mobile_i && (&in_c7);
      clk_stop_o <= &in_c3up;
      snoop_stop_o <= &in_c3up;
      self_refresh_o <= &in_c3up;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boost frequency choice

  // a core counts as busy only while it sits in c0
  // the ratio jumps straight to its target; no ramp is modelled
  reg [2:0] nbusy;
  reg [`CSM_RATIO_W-1:0] lim;
  reg [`CSM_RATIO_W-1:0] pick;
  integer i;
  always @* begin
    nbusy = 3'h0;
    for (i = 0; i < `CSM_NCORE; i = i + 1)
      nbusy = nbusy + {2'h0, busy[i]};
    case (nbusy)
      3'h0, 3'h1: lim = p0_ratio_i;
      3'h2: lim = lim2_ratio_i;
      default: lim = lim4_ratio_i;
    endcase
    // graphics takes headroom when it asks and cores share
    if (gen2_i && gfx_demand_i && nbusy > 3'h1)
      lim = p1_ratio_i;
    if (lim > p0_ratio_i)
      lim = p0_ratio_i;
    if (!p0_req_i || lim < p1_ratio_i)
      pick = p1_ratio_i;
    else
      pick = lim;
  end

  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      core_ratio_o <= {`CSM_RATIO_W{1'b0}};
      gfx_boost_o <= 1'b0;
    end else begin
      core_ratio_o <= pick;
      gfx_boost_o <= gen2_i && gfx_demand_i && (p0_req_i ? nbusy > 3'h1 : 1'b1);
    end
  end

endmodule // csm_mapper
`default_nettype wire

/* bench/csm_os_model.sv */
// software side model that reissues deep idle requests
`timescale 1ns/10ps
`default_nettype none
module csm_os_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [3:0] wake_req_i,
  output var logic [3:0] req_o
);
  always @(posedge clk_i or posedge reset_i)
    if (reset_i) req_o <= 4'h0;
    else req_o <= wake_req_i;
endmodule // csm_os_model
`default_nettype wire

/* bench/csm_mapper_monitor.sv */
// checker for the idle-state mapper outputs
`timescale 1ns/10ps
`default_nettype none
module csm_monitor (
  input wire logic clk_i, reset_i, gen2_i, mobile_i, c7_sel_i, p0_req_i,
  input wire logic [3:0] req_valid_i, demoted_o, wake_req_o,
  input wire logic [7:0] req_type_i, p1_ratio_i, p0_ratio_i, core_ratio_o,
  input wire logic [11:0] cstate_o,
  input wire logic llc_flush_o, clk_stop_o, snoop_stop_o, self_refresh_o
);
  logic [3:0] c0, c3, c7;
  for (genvar k = 0; k < 4; k++) begin : g_c
    assign c0[k] = cstate_o[3*k+:3] == 3'h0;
    assign c3[k] = cstate_o[3*k+:3] >= 3'h3;
    assign c7[k] = cstate_o[3*k+:3] == 3'h7;
  end
  function automatic logic [2:0] f_map(input logic [1:0] t, input logic g, s);
    return t == 2'h3 ? (g && !s ? 3'h6 : 3'h7) : t == 2'h2 ? 3'h3 : {1'b0, t};
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_map;
    req_valid_i[0] && c0[0] |=> demoted_o[0] || cstate_o[2:0] ==
      f_map($past(req_type_i[1:0]), $past(gen2_i), $past(c7_sel_i));
  endproperty
  a_map: assert property (p_map) else $error("bad state map");
  property p_flush;
    1 |=> llc_flush_o == $past(mobile_i && &c7);
  endproperty
  a_flush: assert property (p_flush) else $error("bad flush");
  property p_stop;
    1 |=> clk_stop_o == $past(&c3) && snoop_stop_o == clk_stop_o &&
      self_refresh_o == clk_stop_o;
  endproperty
  a_stop: assert property (p_stop) else $error("bad stop");
  // sampled reset screens the release edge, whose outputs are still zero
  property p_rng;
    !reset_i && p1_ratio_i <= p0_ratio_i |=>
      core_ratio_o >= $past(p1_ratio_i) &&
      core_ratio_o <= $past(p0_ratio_i);
  endproperty
  a_rng: assert property (p_rng) else $error("ratio out of range");
  property p_nop;
    !reset_i && !p0_req_i |=> core_ratio_o == $past(p1_ratio_i);
  endproperty
  a_nop: assert property (p_nop) else $error("ratio not base");
  property p_one;
    (p0_req_i && $onehot(c0)) [*2] |-> core_ratio_o == p0_ratio_i;
  endproperty
  a_one: assert property (p_one) else $error("no top boost");
  // core 1 is the one that the demotion scenario drives
  property p_pls;
    wake_req_o[1] |=> !wake_req_o[1];
  endproperty
  a_pls: assert property (p_pls) else $error("wake pulse long");
  property p_dem;
    demoted_o[1] |-> cstate_o[5:3] inside {3'h1, 3'h3};
  endproperty
  a_dem: assert property (p_dem) else $error("bad demoted state");
endmodule // csm_monitor
bind csm_mapper csm_monitor i_csm_monitor (.*);
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the idle-state mapper
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 1'b0, reset_i = 1'b1, gen2_i = 1'b0, mobile_i = 1'b0;
  logic c7_sel_i = 1'b0, p0_req_i = 1'b0, gfx_demand_i = 1'b0;
  logic [3:0] hist_thresh_i = 4'hF, perf_thresh_i = 4'hF;
  logic [3:0] tb_req = 4'h0, wake_i = 4'h0;
  logic [7:0] req_type_i = 8'h00, p1_ratio_i = 8'h10, p0_ratio_i = 8'h30;
  logic [7:0] lim2_ratio_i = 8'h28, lim4_ratio_i = 8'h20;
  wire [3:0] req_valid_i, os_req, demoted_o, wake_req_o;
  wire [11:0] cstate_o;
  wire [7:0] core_ratio_o;
  wire llc_flush_o, clk_stop_o, snoop_stop_o, self_refresh_o, gfx_boost_o;
  int fail_count = 0;
  int n_tests = 0;
  assign req_valid_i = tb_req | os_req;
  always #12.5 clk_i = ~clk_i;
  csm_mapper i_csm_mapper (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .gen2_i(gen2_i),
    .mobile_i(mobile_i),
    .c7_sel_i(c7_sel_i),
    .hist_thresh_i(hist_thresh_i),
    .perf_thresh_i(perf_thresh_i),
    .req_valid_i(req_valid_i),
    .req_type_i(req_type_i),
    .wake_i(wake_i),
    .p0_req_i(p0_req_i),
    .p1_ratio_i(p1_ratio_i),
    .p0_ratio_i(p0_ratio_i),
    .lim2_ratio_i(lim2_ratio_i),
    .lim4_ratio_i(lim4_ratio_i),
    .gfx_demand_i(gfx_demand_i),
    .cstate_o(cstate_o),
    .demoted_o(demoted_o),
    .wake_req_o(wake_req_o),
    .llc_flush_o(llc_flush_o),
    .clk_stop_o(clk_stop_o),
    .snoop_stop_o(snoop_stop_o),
    .self_refresh_o(self_refresh_o),
    .core_ratio_o(core_ratio_o),
    .gfx_boost_o(gfx_boost_o)
  );
  csm_os_model i_csm_os_model (.clk_i(clk_i), .reset_i(reset_i),
    .wake_req_i(wake_req_o), .req_o(os_req));
  task chk(input string n, input logic [11:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task req(input logic [3:0] m, input logic [1:0] t);
    @(posedge clk_i);
    tb_req <= m;
    req_type_i <= {4{t}};
    @(posedge clk_i);
    tb_req <= 4'h0;
    #1;
  endtask
  task wk(input logic [3:0] m);
    @(posedge clk_i);
    wake_i <= m;
    @(posedge clk_i);
    wake_i <= 4'h0;
  endtask
  task settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task t_map;
    for (int g = 0; g < 3; g++)
      for (int t = 0; t < 4; t++) begin
        gen2_i <= g > 0;
        c7_sel_i <= g == 2;
        req(4'h1, t[1:0]);
        chk("cstate", t < 2 ? t : t == 2 ? 3 : g == 1 ? 6 : 7, cstate_o[2:0]);
        wk(4'h1);
      end
    $display("map test done");
  endtask
  task t_pwr;
    mobile_i <= 1'b1;
    gen2_i <= 1'b0;
    p0_req_i <= 1'b1;
    req(4'hE, 2'h3);
    settle;
    chk("one busy", 8'h30, core_ratio_o);
    chk("early flush", 0, llc_flush_o);
    req(4'h1, 2'h3);
    settle;
    chk("flush", 1, llc_flush_o);
    chk("stop", 3'h7, {clk_stop_o, snoop_stop_o, self_refresh_o});
    wk(4'hF);
    settle;
    chk("four busy", 8'h20, core_ratio_o);
    @(posedge clk_i);
    p0_req_i <= 1'b0;
    settle;
    chk("no boost", 8'h10, core_ratio_o);
    $display("power test done");
  endtask
  task t_gfx;
    @(posedge clk_i);
    p0_req_i <= 1'b1;
    req(4'hC, 2'h1);
    settle;
    chk("two busy", 8'h28, core_ratio_o);
    chk("gfx idle", 0, gfx_boost_o);
    @(posedge clk_i);
    gen2_i <= 1'b1;
    gfx_demand_i <= 1'b1;
    settle;
    chk("gfx share", 8'h10, core_ratio_o);
    chk("gfx boost", 1, gfx_boost_o);
    wk(4'hC);
    gen2_i <= 1'b0;
    gfx_demand_i <= 1'b0;
    p0_req_i <= 1'b0;
    $display("graphics test done");
  endtask
  task t_dem;
    @(posedge clk_i);
    reset_i <= 1'b1;
    hist_thresh_i <= 4'h2;
    perf_thresh_i <= 4'hF;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) begin
      req(4'h2, 2'h3);
      wk(4'h2);
    end
    req(4'h2, 2'h3);
    chk("demoted", 4'h7, {cstate_o[5:3], demoted_o[1]});
    for (int i = 0; i < 17000 && wake_req_o[1] !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (wake_req_o[1] !== 1'b1) begin
      fail_count++;
      finish_test;
    end
    settle;
    chk("undemoted", 4'hE, {cstate_o[5:3], demoted_o[1]});
    wk(4'h2);
    hist_thresh_i <= 4'hF;
    perf_thresh_i <= 4'h2;
    req(4'h2, 2'h3);
    wk(4'h2);
    req(4'h2, 2'h2);
    chk("perf demoted", 4'h3, {cstate_o[5:3], demoted_o[1]});
    $display("demotion test done");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_map;
    t_pwr;
    t_gfx;
    t_dem;
    finish_test;
  end
endmodule // tb
`default_nettype wire
